// [apc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// serial bus master standing in for the host
// ****************************************
module apc_host_model (
	// timing
	input  wire logic clk,
	// bus
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_line
);

	// quarter bit in clk cycles, 2 us per bit at the default
	int q = 50;

	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick();
		repeat (q) @(negedge clk);
	endtask : tick

	// data falls while the clock is high
	task automatic start();
		sda_drv = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_drv = 1'b0;
		tick();
		scl = 1'b0;
		tick();
	endtask : start

	// data rises while the clock is high
	task automatic stop();
		sda_drv = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_drv = 1'b1;
		tick();
	endtask : stop

	// data moves only while the clock is low; a released line reads high
	task automatic bit_xfer(input logic b, output logic s);
		sda_drv = b;
		tick();
		scl = 1'b1;
		tick();
		s = sda_line;
		tick();
		scl = 1'b0;
		tick();
	endtask : bit_xfer

	// msb first, then the receiver's acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], s);
		bit_xfer(1'b1, ack);
	endtask : wbyte

	// low acknowledge asks for another status byte, high ends the read
	task automatic rbyte(output logic [7:0] d, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, d[i]);
		bit_xfer(last, s);
	endtask : rbyte

endmodule : apc_host_model

`default_nettype wire

// [apc_pkg.sv]
package apc_pkg;

	// ****************************************
	// register indices (low subaddress bits)
	// ****************************************
	localparam int unsigned APC_NUM_REGS   = 10;
	localparam logic [3:0]  APC_IDX_SOURCE = 4'h0;
	localparam logic [3:0]  APC_IDX_LOUD   = 4'h1;
	localparam logic [3:0]  APC_IDX_VOLUME = 4'h2;
	localparam logic [3:0]  APC_IDX_TONE   = 4'h3;
	localparam logic [3:0]  APC_IDX_SPK_FL = 4'h4;
	localparam logic [3:0]  APC_IDX_SPK_RL = 4'h5;
	localparam logic [3:0]  APC_IDX_SPK_FR = 4'h6;
	localparam logic [3:0]  APC_IDX_SPK_RR = 4'h7;
	localparam logic [3:0]  APC_IDX_MUTE   = 4'h8;
	localparam logic [3:0]  APC_IDX_DEC    = 4'h9;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned APC_SUB_INC    = 4;
	localparam int unsigned APC_SUB_TEST   = 5;
	localparam int unsigned APC_SRC_GAIN   = 3;
	localparam int unsigned APC_SRC_AM_ST  = 5;
	localparam int unsigned APC_SRC_CD_LOW = 6;
	localparam int unsigned APC_SRC_CD_FUL = 7;
	localparam int unsigned APC_LOUD_FLAT  = 4;
	localparam int unsigned APC_MUTE_SOFT  = 0;
	localparam int unsigned APC_MUTE_SLOW  = 1;
	localparam int unsigned APC_MUTE_ZC_ON = 2;
	localparam int unsigned APC_MUTE_DIR   = 3;
	localparam int unsigned APC_MUTE_ZCRST = 4;
	localparam int unsigned APC_MUTE_WIN   = 5;
	localparam int unsigned APC_MUTE_BSYM  = 7;
	localparam int unsigned APC_ST_PAUSE   = 0;
	localparam int unsigned APC_ST_ZC      = 1;
	localparam int unsigned APC_ST_SOFT    = 2;
	localparam int unsigned APC_ST_STEREO  = 3;

	// ****************************************
	// source codes
	// ****************************************
	localparam logic [2:0] APC_SRC_CD    = 3'h0;
	localparam logic [2:0] APC_SRC_AM    = 3'h3;
	localparam logic [2:0] APC_SRC_BEEP  = 3'h5;

	// ****************************************
	// values after reset, index order
	// ****************************************
	localparam logic [7:0] APC_RST [APC_NUM_REGS] = '{
		8'hFF, 8'h1E, 8'hFF, 8'h7E, 8'h1E,
		8'h1E, 8'h1E, 8'h1E, 8'hF8, 8'hFA
	};
	localparam logic [3:0] APC_BIT_LAST = 4'h8;

	typedef enum logic [3:0] {
		APC_L_IDLE,
		APC_L_ADDR,
		APC_L_ADDR_ACK,
		APC_L_SUB,
		APC_L_SUB_ACK,
		APC_L_WDATA,
		APC_L_WDATA_ACK,
		APC_L_RDATA,
		APC_L_RACK
	} apc_link_e;

endpackage : apc_pkg

// [apc_serial_ctrl.sv]
// Contract
// - start, address byte with read bit, subaddress, acked data bytes, stop.
// - subaddress bit 4 set advances the pointer after every data byte.
// - low four subaddress bits pick one of ten setting registers.
// - subaddress bit 5 is test mode; bits 7 and 6 ignored.
// - read returns status: pause low-active, zc muted, soft mute, stereo.
// - status byte is resampled after every ninth bus clock.
// - reads continue byte after byte without a new address.
// - source bits 2..0 choose cd, decoder, cassette, am, phone, beep.
// - with cd, source bit 7 picks quasi (0) or full (1) differential.
// - source bits 4..3 set input gain 11.25, 7.5, 3.75 or 0 dB.
// - source bit 6 sets cd differential gain 0 or -6 dB.
// - loudness bits 3..0 attenuate 1.25 dB per step; bits 7..5 ignored.
// - loudness bit 4 gives flat attenuation without compensation.
// - mute bit 0 soft mute, bit 1 slope, bit 3 direct mute.
// - bit 2 sets zc mute; clearing releases at next zero crossing.
// - mute bit 4 written one resets zc mute and pause detector.
// - mute bits 6..5 set zero crossing window 160 to 20 mV.
// - mute bit 7 zero selects nonsymmetrical bass cut.
// - mute bit 7 one selects symmetrical bass cut.
// - while mute bit 4 is one zc mute and pause detector stay off.
// - reset: direct mute, soft off, zc held reset, window code 11.
// - reset: no input, 0 dB gain, cd -6 dB, full differential.
`timescale 1ns/1ps
`default_nettype none

module apc_serial_ctrl
	import apc_pkg::*;
#(
	// arbitrary value
	parameter logic [6:0] CHIP_ADDR = 7'h44
) (
	// system
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// serial link
	input  wire logic       link_clk,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// analog state
	input  wire logic       stereo_rx,
	input  wire logic       soft_mute_busy,
	input  wire logic       pause_n,
	input  wire logic       zero_cross,
	// source control
	output logic [2:0]      source_code,
	output logic            source_valid,
	output logic            cd_full_diff,
	output logic            cd_gain_low,
	output logic            am_stereo,
	output logic            beep_on,
	output logic [1:0]      input_gain,
	// level control
	output logic [3:0]      loud_atten,
	output logic            loud_flat,
	output logic [7:0]      volume,
	output logic [7:0]      tone,
	output logic [7:0]      spk_fl,
	output logic [7:0]      spk_rl,
	output logic [7:0]      spk_fr,
	output logic [7:0]      spk_rr,
	output logic [7:0]      decoder_cfg,
	// mute control
	output logic            soft_mute_req,
	output logic            soft_slow,
	output logic            direct_mute,
	output logic            crossing_silence_flag,
	output logic            zc_pause_rst,
	output logic [1:0]      crossing_band_level,
	output logic            bass_sym,
	output logic            test_mode
);

	// ****************************************
	// link domain synchronisers
	// ****************************************
	logic [3:0]  status_q;
	logic [6:0]  lsync;
	logic        ce_l;
	logic        scl_l;
	logic        sda_l;
	logic [3:0]  stat_l;

	apc_sync #(.WIDTH(7)) u_lsync (
		.clk    (link_clk),
		.rst_n  (rst_n),
		.d      ({ce, scl_i, sda_i, status_q}),
		.sync_q (lsync)
	);

	assign ce_l   = lsync[6];
	assign scl_l  = lsync[5];
	assign sda_l  = lsync[4];
	assign stat_l = lsync[3:0];

	// ****************************************
	// link protocol engine
	// ****************************************
	apc_link_e   st_q;
	logic        scl_p_q;
	logic        sda_p_q;
	logic [7:0]  shift_q;
	logic [7:0]  tx_q;
	logic [3:0]  bitc_q;
	logic [3:0]  ptr_q;
	logic        inc_q;
	logic        oe_q;
	logic        rd_q;
	logic        test_q;
	logic [3:0]  wr_addr_q;
	logic [7:0]  wr_data_q;
	logic        wr_tgl_q;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;

	assign rise  = scl_l & ~scl_p_q;
	assign fall  = ~scl_l & scl_p_q;
	assign start = scl_l & scl_p_q & sda_p_q & ~sda_l;
	assign stop  = scl_l & scl_p_q & ~sda_p_q & sda_l;

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else if (ce_l)
		begin
			scl_p_q <= scl_l;
			sda_p_q <= sda_l;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q      <= APC_L_IDLE;
			shift_q   <= 8'h00;
			tx_q      <= 8'h00;
			bitc_q    <= 4'h0;
			ptr_q     <= 4'h0;
			inc_q     <= 1'b0;
			oe_q      <= 1'b0;
			rd_q      <= 1'b0;
			test_q    <= 1'b0;
			wr_addr_q <= 4'h0;
			wr_data_q <= 8'h00;
			wr_tgl_q  <= 1'b0;
		end
		else if (ce_l)
		begin
			if (start)
			begin
				st_q   <= APC_L_ADDR;
				bitc_q <= 4'h0;
				oe_q   <= 1'b0;
			end
			else if (stop)
			begin
				st_q <= APC_L_IDLE;
				oe_q <= 1'b0;
			end
			else
			begin
				case (st_q)
					APC_L_ADDR, APC_L_SUB, APC_L_WDATA:
					begin
						if (rise)
						begin
							shift_q <= {shift_q[6:0], sda_l};
							bitc_q  <= bitc_q + 4'h1;
						end
						else if (fall && bitc_q == APC_BIT_LAST)
						begin
							oe_q <= 1'b1;
							if (st_q == APC_L_ADDR)
							begin
								if (shift_q[7:1] == CHIP_ADDR)
								begin
									st_q <= APC_L_ADDR_ACK;
									rd_q <= shift_q[0];
								end
								else
								begin
									st_q <= APC_L_IDLE;
									oe_q <= 1'b0;
								end
							end
							else if (st_q == APC_L_SUB)
							begin
								st_q   <= APC_L_SUB_ACK;
								ptr_q  <= shift_q[3:0];
								inc_q  <= shift_q[APC_SUB_INC];
								test_q <= shift_q[APC_SUB_TEST];
							end
							else
							begin
								// every byte is acked; the far side drops 10..15
								st_q      <= APC_L_WDATA_ACK;
								wr_addr_q <= ptr_q;
								wr_data_q <= shift_q;
								wr_tgl_q  <= ~wr_tgl_q;
							end
						end
					end
					APC_L_ADDR_ACK:
					begin
						if (fall)
						begin
							bitc_q <= 4'h0;
							if (rd_q)
							begin
								st_q <= APC_L_RDATA;
								tx_q <= {4'h0, stat_l};
								oe_q <= 1'b1;
							end
							else
							begin
								st_q <= APC_L_SUB;
								oe_q <= 1'b0;
							end
						end
					end
					APC_L_SUB_ACK, APC_L_WDATA_ACK:
					begin
						if (fall)
						begin
							st_q   <= APC_L_WDATA;
							bitc_q <= 4'h0;
							oe_q   <= 1'b0;
							if (st_q == APC_L_WDATA_ACK && inc_q)
							begin
								ptr_q <= ptr_q + 4'h1;
							end
						end
					end
					APC_L_RDATA:
					begin
						if (rise)
						begin
							bitc_q <= bitc_q + 4'h1;
						end
						else if (fall)
						begin
							if (bitc_q == APC_BIT_LAST)
							begin
								st_q <= APC_L_RACK;
								oe_q <= 1'b0;
							end
							else
							begin
								tx_q <= {tx_q[6:0], 1'b0};
								oe_q <= ~tx_q[6];
							end
						end
					end
					APC_L_RACK:
					begin
						if (rise && sda_l)
						begin
							st_q <= APC_L_IDLE;
						end
						else if (fall)
						begin
							// fresh sample after the ninth clock
							st_q   <= APC_L_RDATA;
							tx_q   <= {4'h0, stat_l};
							oe_q   <= 1'b1;
							bitc_q <= 4'h0;
						end
					end
					default:
					begin
						oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// enable high pulls the line low; a one bit releases it
	assign sda_o     = 1'b0;
	assign sda_oe    = oe_q;
	assign test_mode = test_q;

	// ****************************************
	// write crossing into system domain
	// ****************************************
	logic wt_s;
	logic wt_p_q;
	logic wr_evt;

	apc_sync #(.WIDTH(1)) u_wsync (
		.clk    (clk),
		.rst_n  (rst_n),
		.d      (wr_tgl_q),
		.sync_q (wt_s)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wt_p_q <= 1'b0;
		end
		else if (ce)
		begin
			wt_p_q <= wt_s;
		end
	end

	assign wr_evt = wt_s ^ wt_p_q;

	// ****************************************
	// setting registers
	// ****************************************
	wire logic [7:0] regs [APC_NUM_REGS];

	for (genvar g = 0; g < APC_NUM_REGS; g++)
	begin : g_reg
		logic [7:0] r_q;
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				r_q <= APC_RST[g];
			end
			else if (ce && wr_evt && wr_addr_q == 4'(g))
			begin
				r_q <= wr_data_q;
			end
		end
		assign regs[g] = r_q;
	end

	assign volume      = regs[APC_IDX_VOLUME];
	assign tone        = regs[APC_IDX_TONE];
	assign spk_fl      = regs[APC_IDX_SPK_FL];
	assign spk_rl      = regs[APC_IDX_SPK_RL];
	assign spk_fr      = regs[APC_IDX_SPK_FR];
	assign spk_rr      = regs[APC_IDX_SPK_RR];
	assign decoder_cfg = regs[APC_IDX_DEC];

	// ****************************************
	// decoded controls
	// ****************************************
	logic [7:0] src;
	logic [7:0] mute;

	assign src  = regs[APC_IDX_SOURCE];
	assign mute = regs[APC_IDX_MUTE];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			source_code         <= 3'h7;
			source_valid        <= 1'b0;
			cd_full_diff        <= 1'b1;
			cd_gain_low         <= 1'b1;
			am_stereo           <= 1'b0;
			beep_on             <= 1'b0;
			input_gain          <= 2'h3;
			loud_atten          <= 4'hE;
			loud_flat           <= 1'b1;
			soft_mute_req       <= 1'b0;
			soft_slow           <= 1'b0;
			direct_mute         <= 1'b1;
			zc_pause_rst        <= 1'b1;
			crossing_band_level <= 2'h3;
			bass_sym            <= 1'b1;
		end
		else if (ce)
		begin
			source_code  <= src[2:0];
			source_valid <= (src[2:0] < APC_SRC_BEEP) ||
				(src[2:0] == APC_SRC_BEEP && !src[APC_SRC_AM_ST]);
			// mode bit kept as written; it only takes effect with the cd source
			cd_full_diff <= src[APC_SRC_CD_FUL];
			cd_gain_low  <= src[APC_SRC_CD_LOW];
			am_stereo    <= src[APC_SRC_AM_ST] && src[2:0] == APC_SRC_AM;
			beep_on      <= !src[APC_SRC_AM_ST] && src[2:0] == APC_SRC_BEEP;
			input_gain   <= src[APC_SRC_GAIN +: 2];
			loud_atten   <= regs[APC_IDX_LOUD][3:0];
			loud_flat    <= regs[APC_IDX_LOUD][APC_LOUD_FLAT];
			soft_mute_req       <= mute[APC_MUTE_SOFT];
			soft_slow           <= mute[APC_MUTE_SLOW];
			direct_mute         <= mute[APC_MUTE_DIR];
			zc_pause_rst        <= mute[APC_MUTE_ZCRST];
			crossing_band_level <= mute[APC_MUTE_WIN +: 2];
			bass_sym            <= mute[APC_MUTE_BSYM];
		end
	end

	// ****************************************
	// zero crossing mute and status
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			crossing_silence_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (mute[APC_MUTE_ZCRST])
			begin
				crossing_silence_flag <= 1'b0;
			end
			else if (mute[APC_MUTE_ZC_ON])
			begin
				crossing_silence_flag <= 1'b1;
			end
			else if (zero_cross)
			begin
				crossing_silence_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_q <= 4'h1;
		end
		else if (ce)
		begin
			status_q[APC_ST_PAUSE]  <= pause_n | mute[APC_MUTE_ZCRST];
			status_q[APC_ST_ZC]     <= crossing_silence_flag;
			status_q[APC_ST_SOFT]   <= soft_mute_busy;
			status_q[APC_ST_STEREO] <= stereo_rx;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_addr_ack: assert property (@(posedge link_clk) disable iff (!rst_n)
		ce_l && !start && !stop && st_q == APC_L_ADDR && fall &&
		bitc_q == APC_BIT_LAST && shift_q[7:1] == CHIP_ADDR |=> oe_q)
		else $error("address match not acknowledged");
	chk_ptr_advance: assert property (@(posedge link_clk) disable iff (!rst_n)
		ce_l && !start && !stop && st_q == APC_L_WDATA_ACK && fall && inc_q
		|=> ptr_q == $past(ptr_q) + 4'h1)
		else $error("pointer did not advance");
	chk_status_fresh: assert property (@(posedge link_clk) disable iff (!rst_n)
		ce_l && !start && !stop && st_q == APC_L_RACK && fall
		|=> tx_q == {4'h0, $past(stat_l)} && st_q == APC_L_RDATA)
		else $error("status not resampled");
	chk_src_write: assert property (@(posedge clk) disable iff (!rst_n)
		ce && wr_evt && wr_addr_q == APC_IDX_SOURCE |=> src == $past(wr_data_q))
		else $error("source write lost");
	chk_high_drop: assert property (@(posedge clk) disable iff (!rst_n)
		wr_evt && wr_addr_q > APC_IDX_DEC
		|=> $stable(mute) && $stable(src) && $stable(decoder_cfg))
		else $error("write above nine changed a setting");
	chk_zc_hold: assert property (@(posedge clk) disable iff (!rst_n)
		ce && crossing_silence_flag && !zero_cross && !mute[APC_MUTE_ZCRST]
		|=> crossing_silence_flag)
		else $error("zc mute released without crossing");
	chk_zc_reset: assert property (@(posedge clk) disable iff (!rst_n)
		ce && mute[APC_MUTE_ZCRST] |=> !crossing_silence_flag)
		else $error("zc mute not reset");
	chk_pause_off: assert property (@(posedge clk) disable iff (!rst_n)
		ce && mute[APC_MUTE_ZCRST] |=> status_q[APC_ST_PAUSE])
		else $error("pause flag active while detector off");
	cov_write: cover property (@(posedge clk) disable iff (!rst_n) wr_evt && ce);
	cov_read_more: cover property (@(posedge link_clk) disable iff (!rst_n)
		st_q == APC_L_RACK && fall);
	cov_autoinc: cover property (@(posedge link_clk) disable iff (!rst_n)
		st_q == APC_L_WDATA_ACK && inc_q && fall);
	cov_zc_release: cover property (@(posedge clk) disable iff (!rst_n)
		crossing_silence_flag ##1 !crossing_silence_flag);

endmodule : apc_serial_ctrl

`default_nettype wire

// [apc_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module apc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

endmodule : apc_sync

`default_nettype wire

// [audio_proc_serial_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module audio_proc_serial_control_tb_top
	import apc_pkg::*;
;
	// arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h2D;
	localparam int         LIMIT    = 95000;

	logic        clk, link_clk, rst_n, scl, host_sda, sda_o, sda_oe;
	logic        stereo_rx, soft_mute_busy, pause_n, zero_cross;
	logic [2:0]  source_code;
	logic [1:0]  input_gain, crossing_band_level;
	logic [3:0]  loud_atten;
	logic        source_valid, cd_full_diff, cd_gain_low, am_stereo, beep_on, loud_flat;
	logic        soft_mute_req, soft_slow, direct_mute, crossing_silence_flag, zc_pause_rst;
	logic        bass_sym, test_mode;
	logic [7:0]  volume, tone, spk_fl, spk_rl, spk_fr, spk_rr, decoder_cfg;
	logic [7:0]  r [10];
	logic [7:0]  stat_q [$];
	logic [31:0] seed = 32'h88AF;
	logic        zc = 1'b0, tm = 1'b0, ce = 1'b1, inc = 1'b0;
	int          ptr = 0, n_fail = 0, checks_done = 0, cyc = 0;
	wire logic   sda_line = host_sda & ~(sda_oe & ~sda_o);

	apc_serial_ctrl #(.CHIP_ADDR(DEV_ADDR)) i_apc_serial_ctrl (
		.clk, .rst_n, .ce, .link_clk, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe,
		.stereo_rx, .soft_mute_busy, .pause_n, .zero_cross, .source_code, .source_valid,
		.cd_full_diff, .cd_gain_low, .am_stereo, .beep_on, .input_gain, .loud_atten,
		.loud_flat, .volume, .tone, .spk_fl, .spk_rl, .spk_fr, .spk_rr, .decoder_cfg,
		.soft_mute_req, .soft_slow, .direct_mute, .crossing_silence_flag, .zc_pause_rst,
		.crossing_band_level, .bass_sym, .test_mode
	);

	apc_host_model i_apc_host_model (.clk, .scl, .sda_drv(host_sda), .sda_line);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_fail++;
			$display("mismatch cycle_limit expected %0d seen %0d", LIMIT - 1, cyc);
			end_sim();
		end
	end

	// ****************************************
	// checking
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic check_all();
		logic [2:0] c;
		logic [7:0] em;
		logic [7:0] gm;
		c = r[0][2:0];
		em = {r[8][7:3], 1'b0, r[8][1], r[8][0]};
		gm = {bass_sym, crossing_band_level, zc_pause_rst, direct_mute, 1'b0, soft_slow,
			soft_mute_req};
		chk("source_code", 8'(c), 8'(source_code));
		chk("source_valid", 8'(c < 5 || (c == 5 && !r[0][5])), 8'(source_valid));
		chk("cd_full_diff", 8'(r[0][7]), 8'(cd_full_diff));
		chk("cd_gain_low", 8'(r[0][6]), 8'(cd_gain_low));
		chk("am_stereo", 8'(r[0][5] && c == 3), 8'(am_stereo));
		chk("beep_on", 8'(c == 5 && !r[0][5]), 8'(beep_on));
		chk("input_gain", 8'(r[0][4:3]), 8'(input_gain));
		chk("loudness", {3'h0, r[1][4:0]}, {3'h0, loud_flat, loud_atten});
		chk("volume", r[2], volume);
		chk("tone", r[3], tone);
		chk("spk_fl", r[4], spk_fl);
		chk("spk_rl", r[5], spk_rl);
		chk("spk_fr", r[6], spk_fr);
		chk("spk_rr", r[7], spk_rr);
		chk("decoder_cfg", r[9], decoder_cfg);
		chk("mute", em, gm);
		chk("zc_flag", 8'(zc), 8'(crossing_silence_flag));
		chk("test_mode", 8'(tm), 8'(test_mode));
	endtask : check_all

	// ****************************************
	// transfers
	// ****************************************
	task automatic send(input logic [7:0] b);
		logic a;
		i_apc_host_model.wbyte(b, a);
		chk("ack", 8'h00, 8'(a));
	endtask : send

	task automatic start_w(input logic [7:0] sub);
		i_apc_host_model.start();
		send({DEV_ADDR, 1'b0});
		send(sub);
		ptr = int'(sub[3:0]);
		inc = sub[APC_SUB_INC];
		tm = sub[APC_SUB_TEST];
	endtask : start_w

	task automatic wdata(input logic [7:0] b);
		send(b);
		if (ptr < 10)
			r[ptr] = b;
		if (ptr == 8)
		begin
			if (b[4])
				zc = 1'b0;
			else if (b[2])
				zc = 1'b1;
		end
		if (inc)
			ptr = (ptr + 1) % 16;
		check_all();
	endtask : wdata

	// en low freezes the block, so the crossing must be missed
	task automatic zc_pulse(input logic en);
		@(negedge clk);
		ce = en;
		zero_cross = 1'b1;
		@(negedge clk);
		zero_cross = 1'b0;
		ce = 1'b1;
		if (en && !r[8][2] && !r[8][4])
			zc = 1'b0;
		repeat (10) @(negedge clk);
		check_all();
	endtask : zc_pulse

	task automatic set_stat();
		@(negedge clk);
		seed = lfsr(seed);
		{stereo_rx, soft_mute_busy, pause_n} = seed[2:0];
		stat_q.push_back({4'h0, seed[2:1], zc, seed[0] | r[8][4]});
	endtask : set_stat

	task automatic rd(input int n);
		logic [7:0] d;
		stat_q.delete();
		set_stat();
		i_apc_host_model.start();
		send({DEV_ADDR, 1'b1});
		for (int k = 0; k < n; k++)
		begin
			set_stat();
			i_apc_host_model.rbyte(d, k == n - 1);
			chk("status", stat_q.pop_front(), d);
		end
		i_apc_host_model.stop();
		$display("test read of %0d bytes finished", n);
	endtask : rd

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic       a;
		logic [7:0] b;
		logic [7:0] tab [8];
		tab = '{8'h80, 8'h48, 8'h11, 8'h1A, 8'h03, 8'h23, 8'h04, 8'h05};
		rst_n = 1'b0;
		{stereo_rx, soft_mute_busy, pause_n, zero_cross} = 4'b0010;
		r = APC_RST;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		check_all();
		$display("test reset finished");
		start_w(8'h00);
		for (int k = 0; k < 8; k++)
			wdata(tab[k]);
		i_apc_host_model.stop();
		i_apc_host_model.start();
		i_apc_host_model.wbyte({~DEV_ADDR, 1'b0}, a);
		chk("foreign_ack", 8'h01, 8'(a));
		i_apc_host_model.stop();
		check_all();
		$display("test source finished");
		i_apc_host_model.q = 80;
		start_w(8'hE8);
		wdata(8'h04);
		wdata(8'h00);
		zc_pulse(1'b0);
		zc_pulse(1'b1);
		wdata(8'h64);
		zc_pulse(1'b1);
		wdata(8'hFB);
		i_apc_host_model.stop();
		i_apc_host_model.q = 50;
		$display("test mute finished");
		rd(2);
		start_w(8'h10);
		for (int k = 0; k < 12; k++)
		begin
			seed = lfsr(seed);
			b = seed[7:0];
			if (k == 0)
				b[2:0] = 3'(seed[15:8] % 8'd5);
			wdata(b);
		end
		i_apc_host_model.stop();
		$display("test burst finished");
		rd(3);
		end_sim();
	end

endmodule : audio_proc_serial_control_tb_top

`default_nettype wire
